// ==== logic/dacrt_pkg.sv ====
package dacrt_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned MUTE_CHANGE_NS = 77000;
  localparam int unsigned MUTE_CYC = MUTE_CHANGE_NS / (1000000000 / CLK_HZ);
  localparam int unsigned MCLK_STOP_NS = 1000;
  localparam int unsigned MCLK_STOP_CYC = MCLK_STOP_NS / (1000000000 / CLK_HZ);
  localparam int unsigned BCK_STOP_CYC = MCLK_STOP_CYC;
  localparam int unsigned LATENCY_BCK = 7;
  localparam int unsigned DATA_W = 7;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int unsigned B_STEREO = 0;
  localparam int unsigned B_LSEL = 1;
  localparam int unsigned B_RSEL = 2;
  localparam int unsigned B_LEFT_PHASE_INVERT = 3;
  localparam int unsigned B_RIGHT_PHASE_INVERT = 4;
  localparam int unsigned B_SOUND = 5;
  localparam int unsigned B_OVR = 6;
  localparam int unsigned B_MUTER = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  typedef enum {DACRT_PD, DACRT_STBY, DACRT_MUTE, DACRT_RUN} dacrt_state_t;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic oe;
  } dacrt_out_t;
endpackage : dacrt_pkg

// ==== logic/dacrt_top.sv ====
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dacrt_top
  import dacrt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // device pins
  input wire logic power_down_n,
  input wire logic control_mode_select,
  input wire logic format_route_pin_hi,
  input wire logic format_route_pin_lo,
  input wire logic sound_pin,
  input wire logic mute_release,
  input wire logic master_clock,
  input wire logic sample_bit_clock,
  input wire logic [DATA_W-1:0] modulator_data_bus,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // outputs
  output dacrt_out_t left_current_output,
  output dacrt_out_t right_current_output,
  output logic sound_quality_mode,
  output logic internal_mute
);
  // pin synchronisers
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] s1, s2;
  logic [DATA_W-1:0] d1, d2;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      d1 <= '0;
      d2 <= '0;
    end
    else
    begin
      s1 <= {power_down_n, control_mode_select, format_route_pin_hi, format_route_pin_lo,
             sound_pin, mute_release, master_clock};
      s2 <= s1;
      d1 <= modulator_data_bus;
      d2 <= d1;
    end
  end
  logic pdn_s, pin_mode, frh, frl, snd_pin, mute_pin, mclk_s;
  assign {pdn_s, pin_mode, frh, frl, snd_pin, mute_pin, mclk_s} = s2;

  logic b1, b2, b3;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b1 <= 1'b0;
      b2 <= 1'b0;
      b3 <= 1'b0;
    end
    else
    begin
      b1 <= sample_bit_clock;
      b2 <= b1;
      b3 <= b2;
    end
  end
  logic bck_rise;
  assign bck_rise = b2 && !b3;

  // control register
  logic [7:0] ctrl;
  logic pdn_q, released, ovr_q, ovr_latched;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RST;
    else if (reg_wr && reg_addr == ADDR_CTRL)
      ctrl <= reg_wdata;
  end

  // power down release on rising edge only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdn_q <= 1'b0;
      released <= 1'b0;
    end
    else
    begin
      pdn_q <= pdn_s;
      if (!pdn_s)
        released <= 1'b0;
      else if (!pdn_q)
        released <= 1'b1;
    end
  end

  // override only counts when it rises after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovr_q <= 1'b0;
      ovr_latched <= 1'b0;
    end
    else
    begin
      ovr_q <= ctrl[B_OVR];
      if (!released || !ctrl[B_OVR] || pin_mode)
        ovr_latched <= 1'b0;
      else if (!ovr_q)
        ovr_latched <= 1'b1;
    end
  end

  // clock presence detectors
  logic m1;
  logic [$clog2(MCLK_STOP_CYC+1)-1:0] mcnt;
  logic [$clog2(BCK_STOP_CYC+1)-1:0] bcnt;
  logic mclk_ok, bck_ok;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m1 <= 1'b0;
      // clocks count as absent until their first edge is seen
      mcnt <= MCLK_STOP_CYC[$bits(mcnt)-1:0];
      bcnt <= BCK_STOP_CYC[$bits(bcnt)-1:0];
    end
    else
    begin
      m1 <= mclk_s;
      if (m1 != mclk_s)
        mcnt <= '0;
      else if (!mclk_ok)
        mcnt <= mcnt;
      else
        mcnt <= mcnt + 1'b1;
      if (bck_rise)
        bcnt <= '0;
      else if (bck_ok)
        bcnt <= bcnt + 1'b1;
    end
  end
  assign mclk_ok = mcnt < MCLK_STOP_CYC[$bits(mcnt)-1:0];
  assign bck_ok = bcnt < BCK_STOP_CYC[$bits(bcnt)-1:0];

  // internal mute with bounded delay
  logic mute_req, mute_q;
  logic [$clog2(MUTE_CYC+1)-1:0] mute_cnt;
  assign mute_req = pin_mode ? !mute_pin : !(mute_pin && ctrl[B_MUTER]);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mute_q <= 1'b1;
      mute_cnt <= '0;
    end
    else if (!released)
    begin
      mute_q <= 1'b1;
      mute_cnt <= '0;
    end
    else if (mute_req == mute_q)
      mute_cnt <= '0;
    else if (mute_req || mute_cnt == MUTE_CYC[$bits(mute_cnt)-1:0] - 1'b1)
    begin
      mute_q <= mute_req;
      mute_cnt <= '0;
    end
    else
      mute_cnt <= mute_cnt + 1'b1;
  end

  // state
  dacrt_state_t state, next_state;
  always_comb
  begin
    next_state = DACRT_RUN;
    if (!released)
      next_state = DACRT_PD;
    else if (!mclk_ok && !ovr_latched)
      next_state = DACRT_STBY;
    else if (mute_q || !bck_ok || !mclk_ok)
      next_state = DACRT_MUTE;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= DACRT_PD;
    else
      state <= next_state;
  end

  // routing and inversion
  logic stereo, lsel, rsel, left_phase_invert, right_phase_invert;
  always_comb
  begin
    if (pin_mode)
    begin
      stereo = !(frh && frl);
      lsel = frh && !frl;
      rsel = frh || !frl;
      left_phase_invert = 1'b0;
      right_phase_invert = 1'b0;
    end
    else
    begin
      stereo = ctrl[B_STEREO];
      lsel = ctrl[B_LSEL] && stereo;
      if (!stereo)
        rsel = 1'b0;
      else
        rsel = !ctrl[B_RSEL];
      left_phase_invert = ctrl[B_LEFT_PHASE_INVERT];
      right_phase_invert = ctrl[B_RIGHT_PHASE_INVERT];
    end
  end

  // sample capture: stereo alternates left then right
  logic [DATA_W-1:0] lsam, rsam;
  logic phase;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lsam <= '0;
      rsam <= '0;
      phase <= 1'b0;
    end
    else if (state != DACRT_RUN)
    begin
      phase <= 1'b0;
      lsam <= '0;
      rsam <= '0;
    end
    else if (bck_rise)
    begin
      phase <= stereo ? !phase : 1'b0;
      if (!stereo || !phase)
        lsam <= d2;
      if (!stereo || phase)
        rsam <= d2;
    end
  end

  // selection then inversion, delayed by bit clocks
  function automatic logic [DATA_W-1:0] inv(input logic en, input logic [DATA_W-1:0] v);
    inv = en ? DATA_W'(-v) : v;
  endfunction : inv
  logic [DATA_W-1:0] lpipe [LATENCY_BCK];
  logic [DATA_W-1:0] rpipe [LATENCY_BCK];
  logic [DATA_W-1:0] lnew, rnew;
  assign lnew = inv(left_phase_invert, lsel ? rsam : lsam);
  assign rnew = inv(right_phase_invert, rsel ? rsam : lsam);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < LATENCY_BCK; i++)
      begin
        lpipe[i] <= '0;
        rpipe[i] <= '0;
      end
    end
    else if (state != DACRT_RUN)
    begin
      for (int i = 0; i < LATENCY_BCK; i++)
      begin
        lpipe[i] <= '0;
        rpipe[i] <= '0;
      end
    end
    else if (bck_rise)
    begin
      lpipe[0] <= lnew;
      rpipe[0] <= rnew;
      for (int i = 1; i < LATENCY_BCK; i++)
      begin
        lpipe[i] <= lpipe[i-1];
        rpipe[i] <= rpipe[i-1];
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_current_output <= '0;
      right_current_output <= '0;
      sound_quality_mode <= 1'b0;
      internal_mute <= 1'b1;
      reg_rdata <= '0;
    end
    else
    begin
      left_current_output.oe <= next_state == DACRT_MUTE || next_state == DACRT_RUN;
      right_current_output.oe <= next_state == DACRT_MUTE || next_state == DACRT_RUN;
      left_current_output.data <= state == DACRT_RUN ? lpipe[LATENCY_BCK-1] : '0;
      right_current_output.data <= state == DACRT_RUN ? rpipe[LATENCY_BCK-1] : '0;
      sound_quality_mode <= pin_mode ? snd_pin : ctrl[B_SOUND];
      internal_mute <= mute_q;
      if (reg_rd && reg_addr == ADDR_CTRL)
        reg_rdata <= ctrl;
      else if (reg_rd && reg_addr == ADDR_STAT)
        reg_rdata <= {4'h0, mute_q, bck_ok, mclk_ok, released};
      else
        reg_rdata <= '0;
    end
  end

  // checker helper: cycles a pending mute change has waited, saturating
  logic [$clog2(MUTE_CYC+2)-1:0] pend_cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_cnt <= '0;
    else if (!released || mute_req == mute_q)
      pend_cnt <= '0;
    else if (pend_cnt <= MUTE_CYC[$bits(pend_cnt)-1:0])
      pend_cnt <= pend_cnt + 1'b1;
  end

  sequence s_pd_low;
    !pdn_s;
  endsequence
  sequence s_mute_pending;
    released && mute_req != mute_q;
  endsequence

  a_pd_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    s_pd_low |-> ##2 !left_current_output.oe) else $error("output driven in power down");
  a_mute_bound: assert property (@(posedge clk) disable iff (!rst_n)
    s_mute_pending |-> pend_cnt < MUTE_CYC[$bits(pend_cnt)-1:0])
    else $error("mute late");
  a_pd_release: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(released) |-> $past(pdn_q) == 1'b0) else $error("release without rising edge");
  a_pd_muted: assert property (@(posedge clk) disable iff (!rst_n)
    !released |-> ##2 internal_mute) else $error("not muted in power down");
  a_stby_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    state == DACRT_STBY |-> !left_current_output.oe) else $error("output driven in standby");
  a_mute_zero: assert property (@(posedge clk) disable iff (!rst_n)
    state == DACRT_MUTE |=> left_current_output.data == '0) else $error("mute data");
  a_sound_sel: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_mode && snd_pin) |=> sound_quality_mode) else $error("sound pin");
endmodule : dacrt_top
`default_nettype wire

// ==== dv/dacrt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module dacrt_host
  import dacrt_pkg::*;
(
  // bench control
  input wire logic bck_run,
  input wire logic mclk_run,
  input wire logic muted,
  input wire logic [DATA_W-1:0] lw,
  input wire logic [DATA_W-1:0] rw,
  // device pins
  output logic master_clock,
  output logic sample_bit_clock,
  output logic [DATA_W-1:0] modulator_data_bus
);
  logic next_l = 1'b1;
  realtime t_rise = 0.0;
  initial
  begin
    master_clock = 1'b0;
    sample_bit_clock = 1'b0;
    modulator_data_bus = '0;
  end
  always @(posedge sample_bit_clock)
    t_rise = $realtime;
  // clocks stand low while stopped
  always #50 master_clock = mclk_run & ~master_clock;
  always #100 sample_bit_clock = bck_run & ~sample_bit_clock;
  // words change on the falling edge, left word first after mute release
  always @(negedge sample_bit_clock)
  begin
    modulator_data_bus <= next_l ? lw : rw;
    next_l <= ~next_l;
  end
  always @(negedge muted)
  begin
    if (!sample_bit_clock)
    begin
      modulator_data_bus <= lw;
      next_l <= 1'b0;
    end
    else
    begin
      // a rise this recent is still the device's first word: count it as left
      next_l <= ($realtime - t_rise) >= 50.0;
    end
  end
endmodule : dacrt_host
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dacrt_pkg::*;
;
  typedef struct packed {
    logic pm;
    logic [1:0] fr;
    logic sp;
    logic [7:0] ctrl;
    logic [DATA_W-1:0] l, r, el, er;
    logic sq;
  } dacrt_row_t;
  localparam dacrt_row_t ROWS [11] = '{
    '{1'b0, 2'h0, 1'b0, 8'h81, 7'h05, 7'h7a, 7'h05, 7'h7a, 1'b0},
    '{1'b0, 2'h0, 1'b0, 8'h85, 7'h05, 7'h7a, 7'h05, 7'h05, 1'b0},
    '{1'b0, 2'h0, 1'b0, 8'h83, 7'h05, 7'h7a, 7'h7a, 7'h7a, 1'b0},
    '{1'b0, 2'h0, 1'b0, 8'h87, 7'h05, 7'h7a, 7'h7a, 7'h05, 1'b0},
    '{1'b0, 2'h0, 1'b0, 8'hb1, 7'h05, 7'h7a, 7'h05, 7'h06, 1'b1},
    '{1'b0, 2'h0, 1'b0, 8'h9f, 7'h05, 7'h7a, 7'h06, 7'h7b, 1'b0},
    '{1'b1, 2'h0, 1'b1, 8'h9f, 7'h05, 7'h7a, 7'h05, 7'h7a, 1'b1},
    '{1'b1, 2'h1, 1'b0, 8'h9f, 7'h05, 7'h7a, 7'h05, 7'h05, 1'b0},
    '{1'b1, 2'h2, 1'b0, 8'h9f, 7'h05, 7'h7a, 7'h7a, 7'h7a, 1'b0},
    '{1'b1, 2'h3, 1'b0, 8'h9f, 7'h11, 7'h11, 7'h11, 7'h11, 1'b0},
    '{1'b0, 2'h0, 1'b0, 8'h8e, 7'h11, 7'h11, 7'h6f, 7'h11, 1'b0}};
  logic clk = 1'b0, rst_n = 1'b0, power_down_n = 1'b0, control_mode_select = 1'b0;
  logic fr_hi = 1'b0, fr_lo = 1'b0, sound_pin = 1'b0, mute_release = 1'b0;
  logic bck_run = 1'b0, mclk_run = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [DATA_W-1:0] lw = 7'h00, rw = 7'h00;
  logic master_clock, sample_bit_clock, sqm, imute;
  logic [DATA_W-1:0] mbus;
  logic [7:0] reg_rdata;
  dacrt_out_t lo, ro;
  int failures = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  dacrt_host dacrt_host_i (.bck_run(bck_run), .mclk_run(mclk_run), .muted(imute), .lw(lw),
    .rw(rw), .master_clock(master_clock), .sample_bit_clock(sample_bit_clock),
    .modulator_data_bus(mbus));
  dacrt_top dacrt_top_i (.clk(clk), .rst_n(rst_n), .power_down_n(power_down_n),
    .control_mode_select(control_mode_select), .format_route_pin_hi(fr_hi),
    .format_route_pin_lo(fr_lo), .sound_pin(sound_pin), .mute_release(mute_release),
    .master_clock(master_clock), .sample_bit_clock(sample_bit_clock),
    .modulator_data_bus(mbus), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .left_current_output(lo),
    .right_current_output(ro), .sound_quality_mode(sqm), .internal_mute(imute));
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask : rd
  // s selects the output enable (1) or the internal mute (0)
  task automatic wait_for(input logic s, input logic v, input int lim);
    int n = 0;
    while ((s ? lo.oe : imute) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("wait", 8'h00, {7'h0, n == lim});
    if (n == lim)
      end_sim;
  endtask : wait_for
  initial
  begin
    #2400000;
    failures++;
    end_sim;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("oe", 8'h00, {7'h0, lo.oe});
    chk("mute", 8'h01, {7'h0, imute});
    repeat (30) @(posedge clk);
    chk("oe", 8'h00, {7'h0, lo.oe});
    power_down_n <= 1'b1;
    rd(ADDR_CTRL, CTRL_RST);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00);
    rd(ADDR_STAT, 8'h09);
    mclk_run <= 1'b1;
    wait_for(1'b1, 1'b1, 100);
    chk("data", 8'h00, {1'b0, lo.data});
    bck_run <= 1'b1;
    mute_release <= 1'b1;
    wr(ADDR_CTRL, 8'h01);
    repeat (MUTE_CYC + 100) @(posedge clk);
    chk("mute", 8'h01, {7'h0, imute});
    wr(ADDR_CTRL, 8'h81);
    wait_for(1'b0, 1'b0, MUTE_CYC + 20);
    foreach (ROWS[i])
    begin
      control_mode_select <= ROWS[i].pm;
      {fr_hi, fr_lo} <= ROWS[i].fr;
      sound_pin <= ROWS[i].sp;
      lw <= ROWS[i].l;
      rw <= ROWS[i].r;
      wr(ADDR_CTRL, ROWS[i].ctrl);
      repeat (LATENCY_BCK + 4) @(posedge sample_bit_clock);
      @(negedge clk);
      chk("left", {1'b0, ROWS[i].el}, {1'b0, lo.data});
      chk("right", {1'b0, ROWS[i].er}, {1'b0, ro.data});
      chk("sound", {7'h0, ROWS[i].sq}, {7'h0, sqm});
    end
    wr(ADDR_CTRL, 8'h81);
    mclk_run <= 1'b0;
    wait_for(1'b1, 1'b0, MCLK_STOP_CYC + 20);
    mclk_run <= 1'b1;
    wait_for(1'b1, 1'b1, 20);
    mute_release <= 1'b0;
    wait_for(1'b0, 1'b1, MUTE_CYC + 20);
    repeat (4) @(negedge clk);
    chk("data", 8'h00, {1'b0, ro.data});
    repeat (4000) @(posedge clk);
    mute_release <= 1'b1;
    wait_for(1'b0, 1'b0, MUTE_CYC + 20);
    power_down_n <= 1'b0;
    mclk_run <= 1'b0;
    bck_run <= 1'b0;
    wait_for(1'b1, 1'b0, 10);
    repeat (30) @(posedge clk);
    power_down_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 8'h40);
    wait_for(1'b1, 1'b1, 20);
    chk("data", 8'h00, {1'b0, lo.data});
    end_sim;
  end
endmodule : testbench
`default_nettype wire
